// ### src/ctc_defs.vh
// Purpose: constants for the calendar time-of-day counter
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   byte offsets, field positions and reset values
`ifndef CTC_DEFS_VH
`define CTC_DEFS_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define CTC_OFS_DIVIDER      6'h00
`define CTC_OFS_SETUP0       6'h04
`define CTC_OFS_SETUP1       6'h08
`define CTC_OFS_CTRL         6'h0C
`define CTC_OFS_ALARM0       6'h10
`define CTC_OFS_ALARM1       6'h14
`define CTC_OFS_TIME_HI      6'h18
`define CTC_OFS_TIME_LO      6'h1C
`define CTC_OFS_INT_RAW      6'h20
`define CTC_OFS_INT_ENABLE   6'h24
`define CTC_OFS_INT_FORCE    6'h28
`define CTC_OFS_INT_STATUS   6'h2C

// ***************************************************************
// field positions
// ***************************************************************
`define CTC_YEAR_HI          23
`define CTC_YEAR_LO          12
`define CTC_MONTH_HI         11
`define CTC_MONTH_LO         8
`define CTC_DAY_HI           4
`define CTC_DAY_LO           0
`define CTC_DOTW_HI          26
`define CTC_DOTW_LO          24
`define CTC_HOUR_HI          20
`define CTC_HOUR_LO          16
`define CTC_MIN_HI           13
`define CTC_MIN_LO           8
`define CTC_SEC_HI           5
`define CTC_SEC_LO           0
`define CTC_CTRL_ENABLE      0
`define CTC_CTRL_RUNNING     1
`define CTC_CTRL_LOAD        4
`define CTC_CTRL_NOLEAP      8
`define CTC_AL0_GLOBAL       28
`define CTC_AL0_YEAR_ENA     26
`define CTC_AL0_MONTH_ENA    25
`define CTC_AL0_DAY_ENA      24
`define CTC_AL1_DOTW_ENA     31
`define CTC_AL1_HOUR_ENA     30
`define CTC_AL1_MIN_ENA      29
`define CTC_AL1_SEC_ENA      28

// ***************************************************************
// reset values and write masks
// ***************************************************************
`define CTC_RST_WORD         32'h00000000
`define CTC_MASK_DIVIDER     32'h0000FFFF
`define CTC_MASK_SETUP0      32'h00FFFF1F
`define CTC_MASK_SETUP1      32'h071F3F3F
`define CTC_MASK_CTRL        32'h00000101
`define CTC_MASK_ALARM0      32'h17FFFF1F
`define CTC_MASK_ALARM1      32'hF71F3F3F
`define CTC_RESP_OKAY        2'h0
`define CTC_RESP_SLVERR      2'h2

`endif

// ### src/ctc_top.v
// Purpose: calendar time-of-day counter with alarm, AXI4-Lite slave
// Assumes: ref_clk_in is a slow reference sampled on aclk
// Notes:   all counting happens on synchronised reference edges
//
// Contract
// - time held as year12, month4, day5, dotw3, hour5, min6, sec6.
// - seconds, minutes wrap at 59; hours wrap at 23 into next day.
// - day counts 1 to month length then back to 1; month 1-12.
// - programmed values are not range checked, just counted on.
// - day of week is Sunday 0 through Saturday 6.
// - day of week only advances at day rollover, wrapping after 6.
// - year divisible by four gives February 29 after February 28.
// - suppress leap day bit makes February 28 go to March 1.
// - leap decision taken only at rollover after Feb 28 23:59:59.
// - alarm fires when global enable set and enabled fields match.
// - fields with enable clear are ignored so alarms recur.
// - alarm drives processor and both oscillator wake outputs.
// - one-second tick divides reference by divider value plus one.
// - divider zero gives a tick on every reference cycle.
// - control writes take effect two reference periods after bus handling.
// - only control passes a two-stage reference-edge pipe; setup and time are read directly.
// - setup may be rewritten while running, then load copies it.
// - low word read captures high word into a holding register.
// - divider is 16 bits in bits 15:0, reset zero.
// - setup word zero: year 23:12, month 11:8, day 4:0.
// - setup word one: dotw 26:24, hour 20:16, min 13:8, sec 5:0.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`include "ctc_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module ctc_top #(
   parameter DIV_W = 16
) (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // reference clock pin
   input  wire        ref_clk_in,
   // axi4-lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire [2:0]  s_axi_awprot,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire [2:0]  s_axi_arprot,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // alarm outputs
   output reg         alarm_irq,
   output reg         ring_oscillator_wake,
   output reg         crystal_oscillator_wake
);

   // ************************************************************
   // registers
   // ************************************************************
   reg  [31:0] divider_reg;
   reg  [31:0] setup0_reg;
   reg  [31:0] setup1_reg;
   reg  [31:0] ctrl_reg;
   reg  [31:0] alarm0_reg;
   reg  [31:0] alarm1_reg;
   reg  [31:0] hold_hi_reg;
   reg         int_raw_reg;
   reg         int_enable_reg;
   reg         int_force_reg;
   reg         load_req_reg;
   reg  [5:0]  aw_addr_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         aw_held_reg;
   reg         w_held_reg;

   // reference side state
   reg  [2:0]       ref_sync_reg;
   reg  [1:0]       en_pipe_reg;
   reg  [1:0]       noleap_pipe_reg;
   reg  [1:0]       load_pipe_reg;
   reg  [DIV_W-1:0] div_cnt_reg;
   reg              update_reg;
   reg  [11:0] year_reg;
   reg  [3:0]  month_reg;
   reg  [4:0]  day_reg;
   reg  [2:0]  dotw_reg;
   reg  [4:0]  hour_reg;
   reg  [5:0]  min_reg;
   reg  [5:0]  sec_reg;

   wire        ref_rise;
   wire        load_now;
   wire        tick;
   wire        running;
   wire        do_write;
   wire        wr_raw_clear;
   wire [31:0] wmask;
   wire [31:0] time_hi;
   wire [31:0] time_lo;
   wire        int_status;
   wire        match;
   wire [5:0]  rd_addr;
   reg  [31:0] rd_data;
   reg         rd_ok;
   reg  [4:0]  month_len;

   // ************************************************************
   // reference edge detect and one-second divider
   // ************************************************************
   // ref_sync_reg[0] is read only by ref_sync_reg[1]
   assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
   assign running  = en_pipe_reg[1];
   // load lands on the second reference edge, same as enable
   assign load_now = ref_rise & load_pipe_reg[0] & ~load_pipe_reg[1];
   // divider read directly; a change while running just retimes
   assign tick = ref_rise & running &
                 (div_cnt_reg == divider_reg[DIV_W-1:0]);

   always @(posedge aclk) begin
      if (!aresetn) begin
         ref_sync_reg    <= 3'h0;
         en_pipe_reg     <= 2'h0;
         noleap_pipe_reg <= 2'h0;
         load_pipe_reg   <= 2'h0;
         div_cnt_reg     <= {DIV_W{1'b0}};
      end else begin
         ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_in};
         if (ref_rise) begin
            // two reference periods from bus write to effect
            en_pipe_reg     <= {en_pipe_reg[0],
                                ctrl_reg[`CTC_CTRL_ENABLE]};
            noleap_pipe_reg <= {noleap_pipe_reg[0],
                                ctrl_reg[`CTC_CTRL_NOLEAP]};
            load_pipe_reg   <= {load_pipe_reg[0], load_req_reg};
            if (!running || tick)
               div_cnt_reg <= {DIV_W{1'b0}};
            else
               div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ************************************************************
   // calendar counting
   // ************************************************************
   always @* begin
      case (month_reg)
         4'h4, 4'h6, 4'h9, 4'hB: month_len = 5'h1E;
         4'h2:    month_len = 5'h1C;
         default: month_len = 5'h1F;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         year_reg   <= 12'h000;
         month_reg  <= 4'h0;
         day_reg    <= 5'h00;
         dotw_reg   <= 3'h0;
         hour_reg   <= 5'h00;
         min_reg    <= 6'h00;
         sec_reg    <= 6'h00;
         update_reg <= 1'b0;
      end else begin
         update_reg <= tick;
         if (load_now) begin
            year_reg  <= setup0_reg[`CTC_YEAR_HI:`CTC_YEAR_LO];
            month_reg <= setup0_reg[`CTC_MONTH_HI:`CTC_MONTH_LO];
            day_reg   <= setup0_reg[`CTC_DAY_HI:`CTC_DAY_LO];
            dotw_reg  <= setup1_reg[`CTC_DOTW_HI:`CTC_DOTW_LO];
            hour_reg  <= setup1_reg[`CTC_HOUR_HI:`CTC_HOUR_LO];
            min_reg   <= setup1_reg[`CTC_MIN_HI:`CTC_MIN_LO];
            sec_reg   <= setup1_reg[`CTC_SEC_HI:`CTC_SEC_LO];
         end else if (tick) begin
            // equality tests only: odd values count on unchecked
            if (sec_reg != 6'h3B) begin
               sec_reg <= sec_reg + 6'h01;
            end else begin
               sec_reg <= 6'h00;
               if (min_reg != 6'h3B) begin
                  min_reg <= min_reg + 6'h01;
               end else begin
                  min_reg <= 6'h00;
                  if (hour_reg != 5'h17) begin
                     hour_reg <= hour_reg + 5'h01;
                  end else begin
                     hour_reg <= 5'h00;
                     // Sunday 0 .. Saturday 6, never recomputed
                     if (dotw_reg == 3'h6)
                        dotw_reg <= 3'h0;
                     else
                        dotw_reg <= dotw_reg + 3'h1;
                     // leap test happens only at this instant
                     if (month_reg == 4'h2 && day_reg == 5'h1C &&
                         year_reg[1:0] == 2'h0 &&
                         !noleap_pipe_reg[1]) begin
                        day_reg <= 5'h1D;
                     end else if (day_reg != month_len &&
                                  !(month_reg == 4'h2 &&
                                    day_reg == 5'h1D)) begin
                        day_reg <= day_reg + 5'h01;
                     end else begin
                        day_reg <= 5'h01;
                        if (month_reg == 4'hC) begin
                           month_reg <= 4'h1;
                           year_reg  <= year_reg + 12'h001;
                        end else begin
                           month_reg <= month_reg + 4'h1;
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // ************************************************************
   // alarm compare and interrupt flag
   // ************************************************************
   assign match = alarm0_reg[`CTC_AL0_GLOBAL] &
      (!alarm0_reg[`CTC_AL0_YEAR_ENA] ||
       year_reg == alarm0_reg[`CTC_YEAR_HI:`CTC_YEAR_LO]) &
      (!alarm0_reg[`CTC_AL0_MONTH_ENA] ||
       month_reg == alarm0_reg[`CTC_MONTH_HI:`CTC_MONTH_LO]) &
      (!alarm0_reg[`CTC_AL0_DAY_ENA] ||
       day_reg == alarm0_reg[`CTC_DAY_HI:`CTC_DAY_LO]) &
      (!alarm1_reg[`CTC_AL1_DOTW_ENA] ||
       dotw_reg == alarm1_reg[`CTC_DOTW_HI:`CTC_DOTW_LO]) &
      (!alarm1_reg[`CTC_AL1_HOUR_ENA] ||
       hour_reg == alarm1_reg[`CTC_HOUR_HI:`CTC_HOUR_LO]) &
      (!alarm1_reg[`CTC_AL1_MIN_ENA] ||
       min_reg == alarm1_reg[`CTC_MIN_HI:`CTC_MIN_LO]) &
      (!alarm1_reg[`CTC_AL1_SEC_ENA] ||
       sec_reg == alarm1_reg[`CTC_SEC_HI:`CTC_SEC_LO]);

   assign int_status = (int_raw_reg & int_enable_reg) | int_force_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         alarm_irq               <= 1'b0;
         ring_oscillator_wake    <= 1'b0;
         crystal_oscillator_wake <= 1'b0;
      end else begin
         alarm_irq               <= int_status;
         ring_oscillator_wake    <= int_status;
         crystal_oscillator_wake <= int_status;
      end
   end

   // ************************************************************
   // axi4-lite write side
   // ************************************************************
   assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign wr_raw_clear = do_write & (aw_addr_reg == `CTC_OFS_INT_RAW) &
                         w_strb_reg[0] & w_data_reg[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready  <= 1'b0;
         s_axi_wready   <= 1'b0;
         s_axi_bvalid   <= 1'b0;
         s_axi_bresp    <= `CTC_RESP_OKAY;
         aw_held_reg    <= 1'b0;
         w_held_reg     <= 1'b0;
         aw_addr_reg    <= 6'h00;
         w_data_reg     <= `CTC_RST_WORD;
         w_strb_reg     <= 4'h0;
         divider_reg    <= `CTC_RST_WORD;
         setup0_reg     <= `CTC_RST_WORD;
         setup1_reg     <= `CTC_RST_WORD;
         ctrl_reg       <= `CTC_RST_WORD;
         alarm0_reg     <= `CTC_RST_WORD;
         alarm1_reg     <= `CTC_RST_WORD;
         int_raw_reg    <= 1'b0;
         int_enable_reg <= 1'b0;
         int_force_reg  <= 1'b0;
         load_req_reg   <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[5:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // load request held until it has crossed, then dropped
         if (load_now)
            load_req_reg <= 1'b0;
         // hardware set wins over a same-cycle software clear
         if (update_reg && match)
            int_raw_reg <= 1'b1;
         else if (wr_raw_clear)
            int_raw_reg <= 1'b0;
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `CTC_RESP_OKAY;
            case (aw_addr_reg)
               `CTC_OFS_DIVIDER: divider_reg <= (divider_reg & ~wmask) |
                  (w_data_reg & wmask & `CTC_MASK_DIVIDER);
               `CTC_OFS_SETUP0: setup0_reg <= (setup0_reg & ~wmask) |
                  (w_data_reg & wmask & `CTC_MASK_SETUP0);
               `CTC_OFS_SETUP1: setup1_reg <= (setup1_reg & ~wmask) |
                  (w_data_reg & wmask & `CTC_MASK_SETUP1);
               `CTC_OFS_CTRL: begin
                  ctrl_reg <= (ctrl_reg & ~wmask) |
                     (w_data_reg & wmask & `CTC_MASK_CTRL);
                  if (w_strb_reg[0] && w_data_reg[`CTC_CTRL_LOAD])
                     load_req_reg <= 1'b1;
               end
               `CTC_OFS_ALARM0: alarm0_reg <= (alarm0_reg & ~wmask) |
                  (w_data_reg & wmask & `CTC_MASK_ALARM0);
               `CTC_OFS_ALARM1: alarm1_reg <= (alarm1_reg & ~wmask) |
                  (w_data_reg & wmask & `CTC_MASK_ALARM1);
               `CTC_OFS_INT_RAW, `CTC_OFS_TIME_HI, `CTC_OFS_TIME_LO,
               `CTC_OFS_INT_STATUS: begin
               end
               `CTC_OFS_INT_ENABLE:
                  if (w_strb_reg[0])
                     int_enable_reg <= w_data_reg[0];
               `CTC_OFS_INT_FORCE:
                  if (w_strb_reg[0])
                     int_force_reg <= w_data_reg[0];
               default: s_axi_bresp <= `CTC_RESP_SLVERR;
            endcase
         end
      end
   end

   // ************************************************************
   // axi4-lite read side
   // ************************************************************
   assign rd_addr = {s_axi_araddr[5:2], 2'h0};
   assign time_hi = {8'h00, year_reg, month_reg, 3'h0, day_reg};
   assign time_lo = {5'h00, dotw_reg, 3'h0, hour_reg, 2'h0, min_reg,
                     2'h0, sec_reg};

   always @* begin
      rd_ok   = 1'b1;
      rd_data = `CTC_RST_WORD;
      case (rd_addr)
         `CTC_OFS_DIVIDER:    rd_data = divider_reg;
         `CTC_OFS_SETUP0:     rd_data = setup0_reg;
         `CTC_OFS_SETUP1:     rd_data = setup1_reg;
         `CTC_OFS_CTRL:       rd_data = {ctrl_reg[31:2], running,
                                         ctrl_reg[0]};
         `CTC_OFS_ALARM0:     rd_data = alarm0_reg;
         `CTC_OFS_ALARM1:     rd_data = alarm1_reg;
         `CTC_OFS_TIME_HI:    rd_data = hold_hi_reg;
         `CTC_OFS_TIME_LO:    rd_data = time_lo;
         `CTC_OFS_INT_RAW:    rd_data = {31'h00000000, int_raw_reg};
         `CTC_OFS_INT_ENABLE: rd_data = {31'h00000000, int_enable_reg};
         `CTC_OFS_INT_FORCE:  rd_data = {31'h00000000, int_force_reg};
         `CTC_OFS_INT_STATUS: rd_data = {31'h00000000, int_status};
         default:             rd_ok   = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `CTC_RST_WORD;
         s_axi_rresp   <= `CTC_RESP_OKAY;
         hold_hi_reg   <= `CTC_RST_WORD;
      end else begin
         s_axi_arready <= ~s_axi_rvalid &
                          ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? `CTC_RESP_OKAY : `CTC_RESP_SLVERR;
            // low word read freezes the matching high word
            if (rd_addr == `CTC_OFS_TIME_LO)
               hold_hi_reg <= time_hi;
         end
      end
   end

endmodule // ctc_top

`default_nettype wire

// ### tb/ctc_properties.sv
// Purpose: port properties of the calendar time-of-day counter
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   sees only top-level ports
`timescale 1ns/1ns
`default_nettype none
module ctc_properties (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // alarm outputs
   input wire logic        alarm_irq,
   input wire logic        ring_oscillator_wake,
   input wire logic        crystal_oscillator_wake
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ************************************************************
   // properties
   // ************************************************************
   a_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> !s_axi_awready && !s_axi_bvalid && !alarm_irq)
      else $error("output active after reset");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   a_aw_drop: assert property (
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("awready stayed high after take");
   a_b_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_b_release: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_r_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_wake_follow: assert property (alarm_irq == ring_oscillator_wake &&
      alarm_irq == crystal_oscillator_wake) else $error("wake differs");
endmodule // ctc_properties
`default_nettype wire

// ### tb/testbench.sv
// Purpose: directed test of the calendar time-of-day counter
// Assumes: reference edges made by hand, seven aclk per period
// Notes:   one bus transfer at a time
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %0t got %h exp %h", $time, g, e); end end
module testbench;
   logic        aclk, aresetn, ref_clk_in;
   logic [31:0] awaddr, wdata, araddr, rd;
   logic        awvalid, wvalid, bready, arvalid, rready;
   wire  [31:0] rdata;
   wire  [1:0]  bresp, rresp;
   wire         awready, wready, bvalid, arready, rvalid;
   wire         irq, ring_wake, xtal_wake;
   int          n_mismatch = 0;
   int          checked = 0;
   logic [31:0] tab [6][5];
   ctc_top DUT (.aclk(aclk), .aresetn(aresetn), .ref_clk_in(ref_clk_in),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .alarm_irq(irq),
      .ring_oscillator_wake(ring_wake), .crystal_oscillator_wake(xtal_wake));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ************************************************************
   // bus and reference tasks
   // ************************************************************
   task automatic wr(input [31:0] a, input [31:0] d, input [1:0] er);
      logic pa, pd;
      pa = 1'b1;
      pd = 1'b1;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (pa || pd) begin
         @(posedge aclk);
         if (pa && awready === 1'b1) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pd && wready === 1'b1) begin
            wvalid <= 1'b0;
            pd = 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      `CHK(bresp, er)
      // ready raised late so the hold of bvalid is exercised
      bready <= 1'b1;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic rdw(input [31:0] a, output [31:0] d, input [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      `CHK(rresp, er)
      rready <= 1'b1;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   task automatic chk_rd(input [31:0] a, input [31:0] e);
      rdw(a, rd, 2'h0);
      `CHK(rd, e)
   endtask
   task automatic chk_time(input [31:0] hi, input [31:0] lo);
      chk_rd(32'h1C, lo);
      chk_rd(32'h18, hi);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge aclk);
         ref_clk_in <= 1'b1;
         repeat (3) @(posedge aclk);
         ref_clk_in <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
   task finish_test;
      if (n_mismatch == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      finish_test;
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      {aresetn, ref_clk_in, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr} = '0;
      tab = '{'{32'h007E821C, 32'h06173B3B, 32'h11, 32'h007E821D, 32'h0},
         '{32'h007E821C, 32'h06173B3B, 32'h111, 32'h007E8301, 32'h0},
         '{32'h007E721C, 32'h01173B3B, 32'h11, 32'h007E7301, 32'h02000000},
         '{32'h007E741E, 32'h05173B3B, 32'h11, 32'h007E7501, 32'h06000000},
         '{32'h007E7C1F, 32'h03173B3B, 32'h11, 32'h007E8101, 32'h04000000},
         '{32'h007E711F, 32'h020A3B3B, 32'h11, 32'h007E711F, 32'h020B0000}};
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      chk_rd(32'h00, 32'h00000000);
      wr(32'h00, 32'hFFFFFFFF, 2'h0);
      chk_rd(32'h00, 32'h0000FFFF);
      rdw(32'h30, rd, 2'h2);
      `CHK(rd, 32'h00000000)
      wr(32'h30, 32'h1, 2'h2);
      wr(32'h00, 32'h2, 2'h0);
      wr(32'h04, 32'h007E711F, 2'h0);
      wr(32'h08, 32'h020A3B3B, 2'h0);
      wr(32'h0C, 32'h11, 2'h0);
      chk_rd(32'h0C, 32'h1);
      pulse(2);
      chk_rd(32'h0C, 32'h3);
      chk_time(32'h007E711F, 32'h020A3B3B);
      pulse(2);
      chk_rd(32'h1C, 32'h020A3B3B);
      pulse(1);
      chk_rd(32'h1C, 32'h020B0000);
      // divider only rewritten while stopped
      wr(32'h0C, 32'h0, 2'h0);
      pulse(2);
      chk_rd(32'h0C, 32'h0);
      wr(32'h00, 32'h0, 2'h0);
      foreach (tab[i]) begin
         wr(32'h04, tab[i][0], 2'h0);
         wr(32'h08, tab[i][1], 2'h0);
         wr(32'h0C, tab[i][2], 2'h0);
         pulse(3);
         chk_time(tab[i][3], tab[i][4]);
      end
      rdw(32'h1C, rd, 2'h0);
      wr(32'h04, 32'h007E8101, 2'h0);
      wr(32'h0C, 32'h11, 2'h0);
      pulse(3);
      chk_rd(32'h18, 32'h007E711F);
      chk_time(32'h007E8101, 32'h020B0000);
      wr(32'h10, 32'h10000000, 2'h0);
      wr(32'h14, 32'h10000000, 2'h0);
      wr(32'h24, 32'h1, 2'h0);
      wr(32'h0C, 32'h11, 2'h0);
      pulse(3);
      `CHK(irq, 1'b1)
      `CHK({ring_wake, xtal_wake}, 2'h3)
      chk_rd(32'h2C, 32'h1);
      wr(32'h20, 32'h1, 2'h0);
      pulse(1);
      `CHK(irq, 1'b0)
      pulse(59);
      `CHK(irq, 1'b1)
      wr(32'h20, 32'h1, 2'h0);
      wr(32'h24, 32'h0, 2'h0);
      pulse(60);
      `CHK(irq, 1'b0)
      chk_rd(32'h20, 32'h1);
      wr(32'h28, 32'h1, 2'h0);
      `CHK(irq, 1'b1)
      wr(32'h28, 32'h0, 2'h0);
      wr(32'h20, 32'h1, 2'h0);
      wr(32'h24, 32'h1, 2'h0);
      wr(32'h10, 32'h0, 2'h0);
      pulse(60);
      `CHK(irq, 1'b0)
      finish_test;
   end
endmodule // testbench
bind ctc_top ctc_properties u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .alarm_irq(alarm_irq), .ring_oscillator_wake(ring_oscillator_wake),
   .crystal_oscillator_wake(crystal_oscillator_wake));
`default_nettype wire
